/* File: cam_ctrl_defines.svh */
// Constants for the control-state decoder of the lookup coprocessor
// Operation
// - Write strobe low with no-op code changes nothing at all.
// - Next-free read gives address low, page on 19..16, zeros above.
// - Only the device with chain input low and free space answers next-free.
// - Masked writes keep bits whose mask bit is high; mask zero is none.
// - Pointer register code writes masked from data bus, reads it back.
// - Setup register code writes masked from data bus, reads it back.
// - Chip-select register code writes masked from data bus, reads it back.
// - Status answered by match device, lowest on mismatch, selected after random; no match is kept, so the device marked last answers instead.
// - Comparand write loads the segment-selected half under that mask half.
// - Comparand read drives the segment-selected half onto the data bus.
// - Mask write loads the selected half of mask n; mask zero ignores it.
// - Mask read gives selected half; for mask zero the value is meaningless.
// - Direct access uses address-select low; all other states hold it high.
// - Direct write stores the half, masked by the setup-chosen mask.
// - Memory writes store the validity line: low valid, high empty.
// - Memory reads drive the stored validity bit on the validity line.
// - Direct reads and writes are refused in software mode.
// - Direct write applies in all selected devices and shows its index.
// - Indirect write stores half at pointer, masked by field, shows index.
// - Pointer, setup, chip-select, comparand and mask reads come from the selected device only, index unchanged.
// - Indirect read drives the selected half of the pointer entry.
// - Direct address is 13 bits on deep parts and 12 bits on small ones.
`ifndef CAM_CTRL_DEFINES_SVH
`define CAM_CTRL_DEFINES_SVH
`define AC_W 13
`define OP_MSB 5
`define MSEL_LSB 6
`define MSEL_MSB 8
`define MSEL_NONE 3'h0
`define CFG_PAGE_LSB 0
`define CFG_PAGE_MSB 3
`define CFG_DMSK_LSB 4
`define CFG_DMSK_MSB 6
`define CFG_LAST_BIT 8
`define DS_SEL_MSB 3
`define CFG_RST 32'h0000_0000
`define DS_RST 32'h0000_0000
`define AR_RST 32'h0000_0000
`define CTRL_RST 32'h0000_0000
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define CTRL_SW_BIT 0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: cam_ctrl_model.sv */
// Model of the switch controller that drives the control and data buses
`timescale 1ns/1ps
`default_nettype none
module cam_ctrl_model (
  input wire logic aclk,
  output logic [12:0] ac_bus,
  output logic write_strobe_n,
  output logic direct_addr_select_n,
  output logic segment_select,
  output logic [31:0] dq_in,
  output logic validity_in_n,
  output logic chain_input_n,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe,
  input wire logic validity_out_n,
  input wire logic validity_oe
);
  // Idle state is a no-op write with the segment low
  initial begin
    ac_bus = 13'h0003;
    write_strobe_n = 1'b0;
    direct_addr_select_n = 1'b1;
    segment_select = 1'b0;
    dq_in = 32'h0000_0000;
    validity_in_n = 1'b1;
    chain_input_n = 1'b0;
  end
  task automatic set_chain(input logic v);
    @(posedge aclk);
    chain_input_n <= v;
  endtask
  // One control state; answer sampled once the next edge has landed
  task automatic run(input logic [12:0] ac, input logic w_n, av_n, seg,
      input logic [31:0] d, input logic vb_n,
      output logic [31:0] q, output logic oe, vq, voe);
    @(posedge aclk);
    ac_bus <= ac;
    write_strobe_n <= w_n;
    direct_addr_select_n <= av_n;
    segment_select <= seg;
    validity_in_n <= vb_n;
    // Released bus keeps changing so a stale value is never trusted
    dq_in <= w_n ? ~dq_in : d;
    @(posedge aclk);
    ac_bus <= 13'h0003;
    write_strobe_n <= 1'b0;
    direct_addr_select_n <= 1'b1;
    segment_select <= 1'b0;
    dq_in <= ~d;
    #1;
    q = dq_out;
    oe = dq_oe;
    vq = validity_out_n;
    voe = validity_oe;
  endtask
endmodule
`default_nettype wire

/* File: cam_ctrl_pkg.sv */
// Types shared by the control-state decoder
package cam_ctrl_pkg;
  typedef enum logic [5:0] {
    op_indirect = 6'h00,
    op_free = 6'h03,
    op_ptr = 6'h04,
    op_cmp = 6'h05,
    op_setup = 6'h06,
    op_status = 6'h07,
    op_chipsel = 6'h08,
    op_mask = 6'h09
  } cmd_t;
  typedef enum logic [0:0] {
    ctx_none = 1'b0,
    ctx_random = 1'b1
  } ctx_t;
endpackage

/* File: cam_register_memory_control_states.sv */
// Control-state decoder for register and memory access of the lookup array
`timescale 1ns/1ps
`default_nettype none
`include "cam_ctrl_defines.svh"
module cam_register_memory_control_states #(
  parameter int ADDR_W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`AC_W-1:0] ac_bus,
  input wire logic write_strobe_n,
  input wire logic direct_addr_select_n,
  input wire logic segment_select,
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic dq_oe,
  input wire logic validity_in_n,
  output logic validity_out_n,
  output logic validity_oe,
  input wire logic chain_input_n,
  output logic full_flag_n,
  output logic [ADDR_W+3:0] index_output_bus
);
  import cam_ctrl_pkg::*;
  localparam int DEPTH = 1 << ADDR_W;
  // Only the two documented array depths are supported
  generate
    if (ADDR_W != 12 && ADDR_W != 13) begin : g_bad_depth
      $error("ADDR_W must be 12 or 13");
    end
  endgenerate
  logic [31:0] ar_r, cfg_r, ds_r, ctrl_r;
  logic [63:0] cmp_r;
  logic [63:0] mask_r [0:7];
  logic [63:0] mem [DEPTH];
  logic [DEPTH-1:0] empty_r;
  ctx_t ctx_r;
  logic [31:0] dq_out_r;
  logic dq_oe_r, vb_out_r, vb_oe_r, ff_r;
  logic [ADDR_W+3:0] idx_r;
  // Decode of the control bus
  logic wr, direct, seg, selected, sw_mode, mem_acc, mem_we;
  logic [2:0] msel, dmsel;
  logic [3:0] page;
  logic [ADDR_W-1:0] ent;
  logic [ADDR_W+3:0] acc_index;
  logic [31:0] mask_half, dmask_half, wmask, old_half, mem_half, cmp_half;
  logic [31:0] mask_lo, st_word;
  logic [63:0] cur_entry;
  logic cur_empty;
  cmd_t cmd;
  assign wr = ~write_strobe_n;
  assign direct = ~direct_addr_select_n;
  assign seg = segment_select;
  assign cmd = cmd_t'(ac_bus[`OP_MSB:0]);
  assign msel = ac_bus[`MSEL_MSB:`MSEL_LSB];
  assign dmsel = cfg_r[`CFG_DMSK_MSB:`CFG_DMSK_LSB];
  assign page = cfg_r[`CFG_PAGE_MSB:`CFG_PAGE_LSB];
  assign selected = ds_r[`DS_SEL_MSB:0] == page;
  assign sw_mode = ctrl_r[`CTRL_SW_BIT];
  // Direct address width follows the array depth
  assign ent = direct ? ac_bus[ADDR_W-1:0] : ar_r[ADDR_W-1:0];
  assign acc_index = {page, ent};
  // Direct access is refused in software mode
  assign mem_acc = selected &
    ((direct & ~sw_mode) | (~direct & cmd == op_indirect));
  assign mem_we = mem_acc & wr;
  assign cur_entry = mem[ent];
  assign cur_empty = empty_r[ent];
  assign mem_half = seg ? cur_entry[63:32] : cur_entry[31:0];
  assign cmp_half = seg ? cmp_r[63:32] : cmp_r[31:0];
  // Mask zero is held at zero, so it never protects a bit
  assign mask_half = seg ? mask_r[msel][63:32] : mask_r[msel][31:0];
  assign mask_lo = mask_r[msel][31:0];
  assign dmask_half = seg ? mask_r[dmsel][63:32] : mask_r[dmsel][31:0];
  assign wmask = direct ? dmask_half : mask_half;
  assign old_half = mem_half;
  assign st_word = 32'({ctx_r, ff_r, idx_r});
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & m) | (new_v & ~m);
  endfunction
  // Highest-priority empty location, lowest index first
  logic [ADDR_W-1:0] nf_idx;
  logic nf_any, nf_owner;
  always_comb begin
    nf_idx = '0;
    nf_any = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (empty_r[i]) begin
        nf_idx = ADDR_W'(i);
        nf_any = 1'b1;
      end
    end
  end
  assign nf_owner = ~chain_input_n & nf_any;
  // Status answers the selected device after random access,
  // otherwise the device marked last in the chain (no match kept here)
  logic st_owner;
  always_comb begin
    unique case (ctx_r)
      ctx_random: st_owner = selected;
      ctx_none: st_owner = cfg_r[`CFG_LAST_BIT];
    endcase
  end
  // Array contents; data is left unreset to keep it in plain RAM
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      if (seg) begin
        mem[ent] <= {merge(old_half, dq_in, wmask), cur_entry[31:0]};
      end else begin
        mem[ent] <= {cur_entry[63:32], merge(old_half, dq_in, wmask)};
      end
    end
  end
  // Validity bits, all empty after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      empty_r <= '1;
    end else if (mem_we) begin
      empty_r[ent] <= validity_in_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff_r <= 1'b1;
    end else begin
      ff_r <= nf_any;
    end
  end
  // Register writes apply in every selected device
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_r <= `AR_RST;
      cfg_r <= `CFG_RST;
      ds_r <= `DS_RST;
      cmp_r <= '0;
    end else if (wr && !direct && selected) begin
      unique case (cmd)
        op_ptr: ar_r <= merge(ar_r, dq_in, mask_lo);
        op_setup: cfg_r <= merge(cfg_r, dq_in, mask_lo);
        op_chipsel: ds_r <= merge(ds_r, dq_in, mask_lo);
        op_cmp: begin
          if (seg) begin
            cmp_r[63:32] <= merge(cmp_r[63:32], dq_in, mask_half);
          end else begin
            cmp_r[31:0] <= merge(cmp_r[31:0], dq_in, mask_half);
          end
        end
        default: ;
      endcase
    end
  end
  // Mask registers; number zero is never written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 8; k++) begin
        mask_r[k] <= '0;
      end
    end else if (wr && !direct && selected && cmd == op_mask &&
                 msel != `MSEL_NONE) begin
      if (seg) begin
        mask_r[msel][63:32] <= dq_in;
      end else begin
        mask_r[msel][31:0] <= dq_in;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctx_r <= ctx_none;
    end else if (mem_acc) begin
      ctx_r <= ctx_random;
    end
  end
  // Index bus shows memory accesses only; register states leave it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r <= '0;
    end else if (mem_acc) begin
      idx_r <= acc_index;
    end
  end
  // Read answers, one cycle after the control state is presented
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_out_r <= '0;
      dq_oe_r <= 1'b0;
      vb_out_r <= 1'b1;
      vb_oe_r <= 1'b0;
    end else begin
      dq_oe_r <= 1'b0;
      vb_oe_r <= 1'b0;
      if (!wr && mem_acc) begin
        dq_out_r <= mem_half;
        dq_oe_r <= 1'b1;
        vb_out_r <= cur_empty;
        vb_oe_r <= 1'b1;
      end else if (!wr && !direct) begin
        unique case (cmd)
          op_free: begin
            if (nf_owner) begin
              dq_out_r <= {12'h000, page,
                           {(16 - ADDR_W){1'b0}}, nf_idx};
              dq_oe_r <= 1'b1;
            end
          end
          op_ptr: begin
            dq_out_r <= ar_r;
            dq_oe_r <= selected;
          end
          op_setup: begin
            dq_out_r <= cfg_r;
            dq_oe_r <= selected;
          end
          op_chipsel: begin
            dq_out_r <= ds_r;
            dq_oe_r <= selected;
          end
          op_status: begin
            dq_out_r <= st_word;
            dq_oe_r <= st_owner;
          end
          op_cmp: begin
            dq_out_r <= cmp_half;
            dq_oe_r <= selected;
          end
          op_mask: begin
            dq_out_r <= mask_half;
            dq_oe_r <= selected;
          end
          default: ;
        endcase
      end
    end
  end
  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign validity_out_n = vb_out_r;
  assign validity_oe = vb_oe_r;
  assign full_flag_n = ff_r;
  assign index_output_bus = idx_r;
  // AXI4-Lite slave: control word and status readback
  logic aw_ok_r, w_ok_r;
  logic [3:0] awaddr_q, wstrb_q;
  logic [31:0] wdata_q;
  logic aw_hs, w_hs, ar_hs, commit;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign commit = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_ok_r <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (commit) begin
        aw_ok_r <= 1'b0;
      end
      s_axi_awready <= ~aw_ok_r & ~aw_hs & ~s_axi_bvalid;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ok_r <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (w_hs) begin
        w_ok_r <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (commit) begin
        w_ok_r <= 1'b0;
      end
      s_axi_wready <= ~w_ok_r & ~w_hs & ~s_axi_bvalid;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q == `OFS_CTRL || awaddr_q == `OFS_STAT) ?
                     `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Status is read-only; a write to it is accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RST;
    end else if (commit && awaddr_q == `OFS_CTRL && wstrb_q[0]) begin
      ctrl_r <= {31'h0000_0000, wdata_q[`CTRL_SW_BIT]};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (s_axi_araddr == `OFS_CTRL) begin
          s_axi_rdata <= ctrl_r;
        end else if (s_axi_araddr == `OFS_STAT) begin
          s_axi_rdata <= st_word;
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic is_reg;
  assign is_reg = ~direct & (cmd != op_indirect);
  a_nop_quiet: assert property (
    wr && !direct && cmd == op_free |=>
      $stable(ar_r) && $stable(cfg_r) && $stable(ds_r) &&
      $stable(empty_r) && $stable(idx_r) && !dq_oe_r)
    else $error("no-op changed state");
  a_free_format: assert property (
    !wr && !direct && cmd == op_free && nf_owner |=>
      dq_oe_r && dq_out_r[31:20] == 12'h000 &&
      dq_out_r[19:16] == $past(page) &&
      dq_out_r[ADDR_W-1:0] == $past(nf_idx))
    else $error("next-free word malformed");
  a_free_scope: assert property (
    !wr && !direct && cmd == op_free && !nf_owner |=> !dq_oe_r)
    else $error("next-free answered by non-owner");
  a_mask_keep: assert property (
    wr && !direct && selected && cmd == op_ptr |=>
      ((ar_r ^ $past(ar_r)) & $past(mask_lo)) == 32'h0000_0000)
    else $error("masked pointer bit changed");
  a_ptr_read: assert property (
    !wr && !direct && selected && cmd == op_ptr |=>
      dq_oe_r && dq_out_r == $past(ar_r))
    else $error("pointer read wrong");
  a_mask_zero: assert property (
    mask_r[0] == 64'h0)
    else $error("mask zero written");
  a_direct_soft: assert property (
    direct && sw_mode |=> !dq_oe_r ##0 $stable(idx_r) ##0 !vb_oe_r)
    else $error("direct access in software mode");
  a_index_show: assert property (
    mem_acc |=> idx_r == $past(acc_index))
    else $error("index not shown");
  a_index_hold: assert property (
    is_reg |=> $stable(idx_r))
    else $error("register state moved index");
  a_valid_read: assert property (
    mem_acc && !wr |=> validity_oe && validity_out_n == $past(cur_empty))
    else $error("validity readback wrong");
  a_valid_store: assert property (
    mem_we |=> empty_r[$past(ent)] == $past(validity_in_n))
    else $error("validity bit not stored");
  c_direct_wr: cover property (direct && wr && mem_acc);
  c_indirect_rd: cover property (!wr && mem_acc ##1 dq_oe_r);
  c_free_rd: cover property (!wr && !direct && cmd == op_free && nf_owner);
  c_masked_wr: cover property (mem_we && wmask != 32'h0000_0000);
endmodule
`default_nettype wire

/* File: cam_register_memory_control_states_test.sv */
// Self-checking bench for the control-state decoder
`timescale 1ns/1ps
`default_nettype none
module cam_register_memory_control_states_test;
  import cam_ctrl_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, write_strobe_n, dq_oe;
  logic direct_addr_select_n, segment_select, validity_in_n, chain_input_n;
  logic validity_out_n, validity_oe, full_flag_n, oe, vq, voe;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dq_in, dq_out, q, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [12:0] ac_bus;
  logic [16:0] index_output_bus;
  int n_fail, checks;
  cam_register_memory_control_states #(.ADDR_W(13)) DUT (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ac_bus, .write_strobe_n, .direct_addr_select_n,
    .segment_select, .dq_in, .dq_out, .dq_oe, .validity_in_n,
    .validity_out_n, .validity_oe, .chain_input_n, .full_flag_n,
    .index_output_bus);
  cam_ctrl_model ctl (.aclk, .ac_bus, .write_strobe_n, .direct_addr_select_n,
    .segment_select, .dq_in, .validity_in_n, .chain_input_n, .dq_out,
    .dq_oe, .validity_out_n, .validity_oe);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic [12:0] oc(input int n, input logic [5:0] op);
    return {4'h0, 3'(n), op};
  endfunction
  task automatic wr(input logic [12:0] ac, input logic [31:0] d,
      input logic seg = 1'b0, vb = 1'b1, av = 1'b1);
    ctl.run(ac, 1'b0, av, seg, d, vb, q, oe, vq, voe);
  endtask
  task automatic rd(input logic [12:0] ac, input logic seg = 1'b0,
      av = 1'b1);
    ctl.run(ac, 1'b1, av, seg, 32'h0, 1'b1, q, oe, vq, voe);
  endtask
  // Address and data offered together, response awaited under a bound
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int i;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      chkb(1'b0, 1'b1);
      print_verdict();
    end
  endtask
  task automatic axr(input logic [3:0] a);
    int i;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      chkb(1'b0, 1'b1);
      print_verdict();
    end
  endtask
  task automatic t_axi();
    axr(4'h0);
    chk(rdat, 32'h0);
    axr(4'h8);
    chk({30'h0, resp}, 32'h2);
    chk(rdat, 32'h0);
    axw(4'h8, 32'h1);
    chk({30'h0, resp}, 32'h2);
  endtask
  task automatic t_regs();
    wr(oc(0, op_ptr), 32'h0000_0005);
    rd(oc(0, op_ptr));
    chk(q, 32'h0000_0005);
    chkb(oe, 1'b1);
    wr(oc(0, op_setup), 32'h0000_0100);
    rd(oc(0, op_setup));
    chk(q, 32'h0000_0100);
    wr(oc(0, op_chipsel), 32'h0000_0120);
    rd(oc(0, op_chipsel));
    chk(q, 32'h0000_0120);
  endtask
  // Mask 1: low half keeps the lower 16 bits, high half the top byte
  task automatic t_mask();
    wr(oc(1, op_mask), 32'h0000_ffff);
    wr(oc(1, op_mask), 32'hff00_0000, 1'b1);
    rd(oc(1, op_mask));
    chk(q, 32'h0000_ffff);
    rd(oc(1, op_mask), 1'b1);
    chk(q, 32'hff00_0000);
    wr(oc(1, op_ptr), 32'hffff_ffff);
    rd(oc(0, op_ptr));
    chk(q, 32'hffff_0005);
    wr(oc(1, op_cmp), 32'h1234_5678, 1'b1);
    wr(oc(0, op_cmp), 32'hcafe_0001);
    rd(oc(0, op_cmp), 1'b1);
    chk(q, 32'h0034_5678);
    rd(oc(0, op_cmp));
    chk(q, 32'hcafe_0001);
  endtask
  task automatic t_nop();
    wr(13'h0003, 32'h0000_0000);
    wr(oc(0, 6'h3f), 32'h0000_0000);
    rd(oc(0, op_ptr));
    chk(q, 32'hffff_0005);
    rd(oc(0, 6'h38));
    chkb(oe, 1'b0);
  endtask
  task automatic t_mem();
    // Mask zero must stay clear, or the pointer write below is masked
    wr(oc(0, op_mask), 32'hffff_ffff);
    wr(oc(0, op_ptr), 32'h0000_0003);
    wr(oc(0, op_indirect), 32'ha1b2_c3d4, 1'b1, 1'b0);
    chk({15'h0, index_output_bus}, 32'h3);
    rd(oc(0, op_indirect), 1'b1);
    chk(q, 32'ha1b2_c3d4);
    chkb(vq, 1'b0);
    chkb(voe, 1'b1);
    wr(oc(0, op_indirect), 32'h1111_1111);
    wr(oc(1, op_indirect), 32'heeee_eeee);
    rd(oc(0, op_indirect));
    chk(q, 32'heeee_1111);
    chkb(vq, 1'b1);
  endtask
  task automatic t_direct();
    wr(13'h1fff, 32'h55aa_55aa, 1'b0, 1'b0, 1'b0);
    chk({15'h0, index_output_bus}, 32'h1fff);
    rd(13'h1fff, 1'b0, 1'b0);
    chk(q, 32'h55aa_55aa);
    chkb(vq, 1'b0);
    axw(4'h0, 32'h1);
    rd(13'h1fff, 1'b0, 1'b0);
    chkb(oe, 1'b0);
    wr(13'h1fff, 32'h0, 1'b0, 1'b0, 1'b0);
    axw(4'h0, 32'h0);
    rd(13'h1fff, 1'b0, 1'b0);
    chk(q, 32'h55aa_55aa);
    wr(13'h0007, 32'h0, 1'b0, 1'b0, 1'b0);
    wr(oc(0, op_setup), 32'h0000_0110);
    wr(13'h0007, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
    wr(oc(0, op_setup), 32'h0000_0100);
    rd(13'h0007, 1'b0, 1'b0);
    chk(q, 32'hffff_0000);
  endtask
  task automatic t_free();
    rd(oc(0, op_free));
    chk(q, 32'h0000_0000);
    wr(13'h0000, 32'h0, 1'b0, 1'b0, 1'b0);
    rd(oc(0, op_free));
    chk(q, 32'h0000_0001);
    chkb(full_flag_n, 1'b1);
    ctl.set_chain(1'b1);
    rd(oc(0, op_free));
    chkb(oe, 1'b0);
    ctl.set_chain(1'b0);
    rd(oc(0, op_status));
    chkb(oe, 1'b1);
    chk(q, 32'h0006_0000);
    axr(4'h4);
    chk(rdat, 32'h0006_0000);
    chk({30'h0, resp}, 32'h0);
  endtask
  // Deselection cannot be undone over the control bus, so it runs last
  task automatic t_desel();
    wr(oc(0, op_chipsel), 32'h0000_0001);
    rd(oc(0, op_ptr));
    chkb(oe, 1'b0);
  endtask
  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(oc(0, op_status));
    chkb(oe, 1'b0);
    t_axi();
    t_regs();
    t_mask();
    t_nop();
    t_mem();
    t_direct();
    t_free();
    t_desel();
    print_verdict();
  end
endmodule
`default_nettype wire
